// ==== rtl/psg_pkg.sv ====
// Purpose: Shared constants, register map and types of the pointer sequence generator.
// Assumes: 10 MHz core clock; all sequence timing runs on a 0.5 ms tick.
// Notes: Durations are kept in their own unit and converted to ticks here.
package psg_pkg;
   // Timebase.
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned HTICK_NS = 500_000;
   localparam int unsigned HTICK_CYC_DEF = (HTICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned HTICK_US = 500;
   localparam int unsigned HT_PER_MS = 1000 / HTICK_US;
   localparam int TW = 18;
   localparam int IW = 7;
   localparam int RW = 14;
   localparam int DW = 32;
   localparam int AW = 8;
   typedef logic [TW-1:0] psg_ticks_t;
   typedef logic [IW-1:0] psg_idx_t;
   typedef logic [RW-1:0] psg_rate_t;
   localparam psg_ticks_t HT_ONE = 18'h0_0001;
   localparam psg_idx_t IDX_ONE = 7'h01;
   // Durations in their printed units.
   localparam int unsigned REPEAT_MS = 30000;
   localparam int unsigned COOL_MS = 60000;
   localparam int unsigned INIT_STEP_MS = 1000;
   localparam int unsigned STS_GAP_US = 500;
   localparam int unsigned VT_GAP_US = 2000;
   localparam int unsigned PH_SHORT_MS = 250;
   localparam int unsigned PH_LONG_MS = 500;
   // Durations in ticks.
   localparam psg_ticks_t GROUP_HT = psg_ticks_t'(REPEAT_MS * HT_PER_MS);
   localparam psg_ticks_t COOL_HT = psg_ticks_t'(COOL_MS * HT_PER_MS);
   localparam psg_ticks_t INIT_HT = psg_ticks_t'(INIT_STEP_MS * HT_PER_MS);
   localparam psg_ticks_t STS_GAP_HT = psg_ticks_t'(STS_GAP_US / HTICK_US);
   localparam psg_ticks_t VT_GAP_HT = psg_ticks_t'(VT_GAP_US / HTICK_US);
   localparam psg_ticks_t PH_SHORT_HT = psg_ticks_t'(PH_SHORT_MS * HT_PER_MS);
   localparam psg_ticks_t PH_LONG_HT = psg_ticks_t'(PH_LONG_MS * HT_PER_MS);
   // Event counts and slot positions, one-based.
   localparam psg_idx_t INIT_COUNT = 7'd30;
   localparam psg_idx_t SINGLE_COUNT = 7'd1;
   localparam psg_idx_t BURST_COUNT = 7'd3;
   localparam psg_idx_t PHASE_COUNT = 7'd7;
   localparam psg_idx_t PH_SHORT_N = 7'd2;
   localparam psg_idx_t DALT_COUNT = 7'd2;
   localparam psg_idx_t C87_LEN = 7'd90;
   localparam psg_idx_t C87_ON = 7'd87;
   localparam psg_idx_t C87_CAN = 7'd87;
   localparam psg_idx_t C87_ADD = 7'd43;
   localparam psg_idx_t C26_LEN = 7'd27;
   localparam psg_idx_t C26_ON = 7'd26;
   localparam psg_idx_t C26_CAN = 7'd26;
   localparam psg_idx_t C26_ADD = 7'd13;
   // Interval limits in ms.
   localparam psg_rate_t PC_MIN_MS = 14'd34;
   localparam psg_rate_t STS_MIN_MS = 14'd340;
   localparam psg_rate_t VT_MIN_MS = 14'd1000;
   localparam psg_rate_t RATE_MAX_MS = 14'd10000;
   localparam psg_rate_t RATE_RST = 14'd1000;
   // Register map.
   localparam logic [AW-1:0] CTRL_OFS = 8'h00;
   localparam logic [AW-1:0] RATE_OFS = 8'h04;
   localparam logic [AW-1:0] STAT_OFS = 8'h08;
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_INIT_BIT = 1;
   localparam int CTRL_DEC_BIT = 2;
   localparam int CTRL_VT_BIT = 3;
   localparam int CTRL_MODE_LSB = 4;
   localparam int MODE_W = 4;
   localparam int STAT_RUN_BIT = 0;
   localparam int STAT_PH_LSB = 1;
   localparam int STAT_REF_BIT = 3;
   typedef enum logic [MODE_W-1:0] {
      M_SINGLE, M_BURST, M_PHASE, M_PC, M_PC_CAN, M_PC_ADD, M_87, M_87_CAN,
      M_87_ADD, M_26, M_26_CAN, M_26_ADD, M_SALT, M_DALT
   } psg_mode_t;
   typedef enum logic [1:0] {PH_IDLE, PH_INIT, PH_COOL, PH_SEQ} psg_phase_t;
   typedef struct packed {
      logic req;
      logic dec;
   } psg_evt_t;
   typedef struct packed {
      psg_mode_t mode;
      logic vt;
      logic dec;
      logic init_en;
      psg_rate_t rate;
   } psg_cfg_t;
   localparam psg_cfg_t CFG_RST = '{mode: M_SINGLE, vt: 1'b0, dec: 1'b0,
                                    init_en: 1'b1, rate: RATE_RST};
endpackage

// ==== rtl/psg_tick.sv ====
// Purpose: Divides the core clock down to a one-cycle 0.5 ms tick.
// Assumes: CYC is at least 2, so two ticks never touch.
// Notes: A clear realigns the tick so a run starts on a whole tick.
`timescale 1ns/10ps
module psg_tick #(
   parameter int unsigned CYC = 5000
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Control
   input wire logic clr,
   // Tick out
   output logic tick
);
   localparam int CW = $clog2(CYC);
   localparam logic [CW-1:0] LAST = CW'(CYC - 1);
   logic [CW-1:0] cnt_q;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= '0;
         tick <= 1'b0;
      end else begin
         cnt_q <= (clr || cnt_q == LAST) ? '0 : cnt_q + 1'b1;
         tick <= ~clr & (cnt_q == LAST);
      end
   end
endmodule // psg_tick

// ==== rtl/psg_core.sv ====
// Purpose: Schedules pointer adjustment requests for the frame generator.
// Assumes: APB master per the protocol; frame generator takes one pulse per move.
// Notes: Configuration is frozen while a run is active.
// How it works
// R1: Runs initialization, cool-down, then sequence phases.
// R2: Optional init: one move per second, 30 s.
// R3: Cool-down lasts 60 s with pattern already running.
// R4: Sequence phase repeats pattern until stopped.
// R5: Single: one move every 30 s.
// R6: Burst: three moves, 0.5/2 ms apart, 30 s.
// R7: Phase transient: seven moves, fixed gaps, 30 s.
// R8: Periodic continuous: evenly spaced programmed interval.
// R9: Cancel one move every N intervals.
// R10: Added move follows normal by 0.5/2 ms.
// R11: 87-3: 87 moves then 3 omitted.
// R12: 87-3 cancel: drop 87th every N cycles.
// R13: 87-3 add: extra after 43rd every N cycles.
// R14: 26-1: 26 VT moves then 1 omitted.
// R15: 26-1 cancel: drop 26th every N cycles.
// R16: 26-1 add: extra 2 ms after 13th.
// R17: Single alternating: direction flips each move.
// R18: Double alternating: pairs 2 ms apart, flipping.
// R19: Refuse sequence types invalid for pointer type.
// R20: Direction bit sets increment or decrement; alternating modes ignore it and start on increment.
// R21: One start/stop control toggles the run.
// R22: Init length fixed, only enabled or not.
// R23: Half-millisecond tick drives all timing.
// R24: Each move is a one-cycle request pulse.
`timescale 1ns/10ps
module psg_core #(
   parameter int unsigned TICK_CYC = psg_pkg::HTICK_CYC_DEF
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [psg_pkg::AW-1:0] paddr,
   input wire logic [psg_pkg::DW-1:0] pwdata,
   output logic [psg_pkg::DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Frame generator side
   output psg_pkg::psg_evt_t ptr_evt,
   output logic running
);
   import psg_pkg::*;

   logic ht;
   psg_phase_t phase_q, phase_d;
   psg_cfg_t cfg_q, cfg_d, cfg_wr;
   psg_ticks_t wait_q, wait_d;
   psg_ticks_t gsum_q, gsum_d;
   psg_ticks_t acc_q, acc_d;
   psg_ticks_t cool_q, cool_d;
   psg_idx_t idx_q, idx_d;
   logic arm_q, arm_d;
   logic add_q, add_d;
   logic alt_q, alt_d;
   logic ref_q, ref_d;
   psg_evt_t evt_q, evt_d;
   logic [DW-1:0] rdata_q, rdata_d, ctrl_word, stat_word;

   function automatic logic cfg_ok(input psg_cfg_t c);
      logic need;
      logic ok;
      psg_rate_t lo;
      need = 1'b1;
      ok = 1'b1;
      lo = PC_MIN_MS;
      case (c.mode)
         M_SINGLE, M_BURST, M_PHASE, M_SALT, M_DALT: need = 1'b0;
         M_PC, M_PC_CAN: lo = PC_MIN_MS;
         M_PC_ADD: lo = c.vt ? VT_MIN_MS : STS_MIN_MS;
         M_87, M_87_CAN, M_87_ADD: begin
            ok = ~c.vt;
            lo = STS_MIN_MS;
         end
         M_26, M_26_CAN, M_26_ADD: begin
            ok = c.vt;
            lo = VT_MIN_MS;
         end
         default: ok = 1'b0;
      endcase
      return ok & (~need | (c.rate >= lo && c.rate <= RATE_MAX_MS));
   endfunction

   // Bus decode.
   wire logic setup = psel & ~penable;
   wire logic access = psel & penable;
   wire logic sel_ctrl = (paddr == CTRL_OFS);
   wire logic sel_rate = (paddr == RATE_OFS);
   wire logic sel_stat = (paddr == STAT_OFS);
   wire logic mapped = sel_ctrl | sel_rate | sel_stat;
   wire logic wr_ctrl = access & pwrite & sel_ctrl;
   wire logic wr_rate = access & pwrite & sel_rate;
   wire logic idle = (phase_q == PH_IDLE);
   wire logic start_wr = wr_ctrl & pwdata[CTRL_RUN_BIT];
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;
   assign prdata = rdata_q;
   assign running = ~idle;
   assign ptr_evt = evt_q;

   assign cfg_wr = '{mode: psg_mode_t'(pwdata[CTRL_MODE_LSB +: MODE_W]),
                     vt: pwdata[CTRL_VT_BIT], dec: pwdata[CTRL_DEC_BIT],
                     init_en: pwdata[CTRL_INIT_BIT], rate: cfg_q.rate};
   wire logic start_ok = idle & start_wr & cfg_ok(cfg_wr); // see R19

   // Restarting the divider makes every run begin on a whole tick.
   psg_tick #(.CYC(TICK_CYC)) u_tick ( // see R23
      .core_clk(core_clk),
      .arst_n(arst_n),
      .clr(start_ok),
      .tick(ht)
   );

   // Pattern decode.
   psg_mode_t mode;
   assign mode = cfg_q.mode;
   wire logic is_87 = mode inside {M_87, M_87_CAN, M_87_ADD};
   wire logic is_26 = mode inside {M_26, M_26_CAN, M_26_ADD};
   wire logic is_pc = mode inside {M_PC, M_PC_CAN, M_PC_ADD};
   wire logic m_can = mode inside {M_PC_CAN, M_87_CAN, M_26_CAN};
   wire logic m_add = mode inside {M_PC_ADD, M_87_ADD, M_26_ADD};
   wire logic is_alt = mode inside {M_SALT, M_DALT};
   wire logic is_grp = ~(is_87 | is_26 | is_pc);
   wire logic evt_dir = is_alt ? alt_q : cfg_q.dec; // see R20

   psg_ticks_t iv, agap, grp_gap, acc_n;
   psg_idx_t grp_cnt, cyc_len, cyc_on, hit_slot;
   assign iv = psg_ticks_t'(cfg_q.rate) * psg_ticks_t'(HT_PER_MS); // see R8
   assign agap = cfg_q.vt ? VT_GAP_HT : STS_GAP_HT; // see R6, R10
   assign grp_cnt = (mode == M_BURST) ? BURST_COUNT :
                    (mode == M_PHASE) ? PHASE_COUNT :
                    (mode == M_DALT) ? DALT_COUNT : SINGLE_COUNT; // see R5
   assign grp_gap = (mode == M_PHASE) ?
                    ((idx_q < PH_SHORT_N) ? PH_SHORT_HT : PH_LONG_HT) : // see R7
                    (mode == M_DALT) ? VT_GAP_HT : agap; // see R18
   assign cyc_len = is_87 ? C87_LEN : C26_LEN; // see R11, R14
   assign cyc_on = is_87 ? C87_ON : C26_ON;
   assign hit_slot = is_87 ? (m_can ? C87_CAN : C87_ADD) : // see R12, R13
                     (m_can ? C26_CAN : C26_ADD); // see R15, R16
   assign acc_n = acc_q + iv;
   // The accumulator yields the smallest N whose span reaches 30 s without a divider.
   wire logic anom = is_pc ? (acc_n >= GROUP_HT) : // see R9
                     (arm_q & (idx_q == hit_slot - IDX_ONE));
   wire logic slot_on = is_pc | (idx_q < cyc_on);
   wire logic last_slot = (idx_q == cyc_len - IDX_ONE);
   wire logic arm_now = acc_n >= GROUP_HT;

   always_comb begin
      phase_d = phase_q;
      cfg_d = cfg_q;
      wait_d = wait_q;
      gsum_d = gsum_q;
      acc_d = acc_q;
      cool_d = cool_q;
      idx_d = idx_q;
      arm_d = arm_q;
      add_d = add_q;
      alt_d = alt_q;
      ref_d = ref_q;
      evt_d = '{req: 1'b0, dec: evt_q.dec};
      if (idle && wr_ctrl) begin
         cfg_d = cfg_wr;
      end
      if (idle && wr_rate) begin
         cfg_d.rate = pwdata[RW-1:0];
      end
      case (phase_q)
         PH_IDLE: begin
            if (start_wr) begin
               ref_d = ~start_ok; // see R19
               if (start_ok) begin
                  phase_d = cfg_wr.init_en ? PH_INIT : PH_COOL; // see R1, R22
                  wait_d = cfg_wr.init_en ? INIT_HT - HT_ONE : '0;
                  idx_d = '0;
                  gsum_d = '0;
                  acc_d = '0;
                  cool_d = '0;
                  arm_d = 1'b0;
                  add_d = 1'b0;
                  alt_d = 1'b0;
               end
            end
         end
         PH_INIT: begin
            if (ht) begin
               if (wait_q != '0) begin
                  wait_d = wait_q - HT_ONE;
               end else begin
                  evt_d = '{req: 1'b1, dec: evt_dir}; // see R2
                  if (idx_q == INIT_COUNT - IDX_ONE) begin
                     phase_d = PH_COOL; // see R1
                     wait_d = '0;
                     idx_d = '0;
                  end else begin
                     idx_d = idx_q + IDX_ONE;
                     wait_d = INIT_HT - HT_ONE;
                  end
               end
            end
         end
         PH_COOL, PH_SEQ: begin
            if (ht) begin
               if (phase_q == PH_COOL) begin
                  cool_d = cool_q + HT_ONE;
                  if (cool_q == COOL_HT - HT_ONE) begin
                     phase_d = PH_SEQ; // see R3
                  end
               end
               if (wait_q != '0) begin
                  wait_d = wait_q - HT_ONE;
               end else if (is_grp) begin
                  evt_d = '{req: 1'b1, dec: evt_dir};
                  if (idx_q == grp_cnt - IDX_ONE) begin
                     // The group closes on the 30 s grid whatever its inner gaps were.
                     wait_d = GROUP_HT - gsum_q - HT_ONE; // see R5, R6, R7
                     idx_d = '0;
                     gsum_d = '0;
                     alt_d = ~alt_q; // see R17, R18
                  end else begin
                     wait_d = grp_gap - HT_ONE;
                     gsum_d = gsum_q + grp_gap;
                     idx_d = idx_q + IDX_ONE;
                  end
               end else if (add_q) begin
                  evt_d = '{req: 1'b1, dec: evt_dir}; // see R10
                  wait_d = iv - agap - HT_ONE;
                  add_d = 1'b0;
               end else begin
                  evt_d.req = slot_on & ~(anom & m_can); // see R11, R12, R15
                  evt_d.dec = evt_dir;
                  if (anom && m_add) begin
                     add_d = 1'b1; // see R13, R16
                     wait_d = agap - HT_ONE;
                  end else begin
                     wait_d = iv - HT_ONE; // see R8
                  end
                  if (is_pc) begin
                     acc_d = anom ? '0 : acc_n; // see R9
                  end else begin
                     idx_d = last_slot ? '0 : idx_q + IDX_ONE; // see R14
                     arm_d = last_slot ? arm_now : arm_q;
                     acc_d = (last_slot && arm_now) ? '0 : acc_n;
                  end
               end
            end
         end
         default: phase_d = PH_IDLE;
      endcase
      if (!idle && start_wr) begin
         phase_d = PH_IDLE; // see R21, R4
         evt_d.req = 1'b0;
      end
   end

   always_comb begin
      ctrl_word = '0;
      ctrl_word[CTRL_RUN_BIT] = running;
      ctrl_word[CTRL_INIT_BIT] = cfg_q.init_en;
      ctrl_word[CTRL_DEC_BIT] = cfg_q.dec;
      ctrl_word[CTRL_VT_BIT] = cfg_q.vt;
      ctrl_word[CTRL_MODE_LSB +: MODE_W] = cfg_q.mode;
      stat_word = '0;
      stat_word[STAT_RUN_BIT] = running;
      stat_word[STAT_PH_LSB +: 2] = phase_q;
      stat_word[STAT_REF_BIT] = ref_q;
   end
   assign rdata_d = sel_ctrl ? ctrl_word :
                    sel_rate ? DW'(cfg_q.rate) :
                    sel_stat ? stat_word : '0;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_q <= PH_IDLE;
         cfg_q <= CFG_RST;
         wait_q <= '0;
         gsum_q <= '0;
         acc_q <= '0;
         cool_q <= '0;
         idx_q <= '0;
         arm_q <= 1'b0;
         add_q <= 1'b0;
         alt_q <= 1'b0;
         ref_q <= 1'b0;
         evt_q <= '0;
         rdata_q <= '0;
      end else begin
         phase_q <= phase_d;
         cfg_q <= cfg_d;
         wait_q <= wait_d;
         gsum_q <= gsum_d;
         acc_q <= acc_d;
         cool_q <= cool_d;
         idx_q <= idx_d;
         arm_q <= arm_d;
         add_q <= add_d;
         alt_q <= alt_d;
         ref_q <= ref_d;
         evt_q <= evt_d; // see R24
         rdata_q <= setup ? rdata_d : rdata_q;
      end
   end

   // Checking helpers: ticks since the last request and its direction.
   psg_ticks_t since_q;
   logic pat_q;
   logic last_dec_q;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         since_q <= '0;
         pat_q <= 1'b0;
         last_dec_q <= 1'b0;
      end else begin
         since_q <= (idle || ptr_evt.req) ? '0 : since_q + psg_ticks_t'(ht);
         pat_q <= idle ? 1'b0 : ptr_evt.req ? (phase_q != PH_INIT) : pat_q;
         last_dec_q <= ptr_evt.req ? ptr_evt.dec : last_dec_q;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_init_done;
      (phase_q == PH_INIT) ##1 (phase_q == PH_COOL);
   endsequence
   sequence s_stop;
      running && start_wr;
   endsequence

   a_init_thirty: assert property (s_init_done |-> $past(idx_q) == INIT_COUNT - IDX_ONE) // see R2
      else $error("init phase did not end after thirty moves");
   a_skip_init: assert property (start_ok && !cfg_wr.init_en |=> phase_q == PH_COOL) // see R22
      else $error("disabled init was not skipped");
   a_cool_len: assert property ((phase_q == PH_SEQ) && ($past(phase_q) == PH_COOL) // see R3
      |-> $past(cool_q) == COOL_HT - HT_ONE)
      else $error("cool-down length wrong");
   a_seq_holds: assert property ((phase_q == PH_SEQ) && !start_wr |=> phase_q == PH_SEQ) // see R4
      else $error("sequence phase left without stop");
   a_stop_toggle: assert property (s_stop |=> idle && !ptr_evt.req) // see R21
      else $error("stop did not halt the run");
   a_bad_refused: assert property (idle && start_wr && !cfg_ok(cfg_wr) |=> idle && ref_q) // see R19
      else $error("invalid sequence type was started");
   a_idle_quiet: assert property (idle |=> !ptr_evt.req) // see R24
      else $error("request while idle");
   a_req_pulse: assert property (ptr_evt.req |=> !ptr_evt.req) // see R24
      else $error("request longer than one cycle");
   a_single_gap: assert property (ptr_evt.req && mode == M_SINGLE && phase_q == PH_SEQ // see R5
      && pat_q |-> since_q == GROUP_HT)
      else $error("single mode spacing wrong");
   a_alt_flip: assert property (ptr_evt.req && mode == M_SALT && phase_q == PH_SEQ // see R17
      && pat_q |-> ptr_evt.dec != last_dec_q)
      else $error("alternating direction did not flip");
endmodule // psg_core

// ==== bench/psg_fg_model.sv ====
// Purpose: Stand-in for the frame generator logic that inserts pointer moves.
// Assumes: One request pulse per move, sampled on the rising edge of core_clk.
// Notes: Each move is stamped with its edge count so the bench can check spacing.
`timescale 1ns/10ps
module psg_fg_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Moves from the sequencer
   input wire psg_pkg::psg_evt_t ptr_evt,
   // Status to the bench
   output logic long_pulse
);
   import psg_pkg::*;
   int cyc = 0;
   int stamp[$];
   logic dir[$];
   logic req_q = 1'b0;
   initial long_pulse = 1'b0;
   // A request seen on two edges in a row would be taken as two moves, so it is flagged.
   always @(posedge core_clk) begin
      if (ptr_evt.req === 1'b1) begin
         stamp.push_back(cyc);
         dir.push_back(ptr_evt.dec);
         if (req_q === 1'b1) long_pulse <= 1'b1;
      end
      req_q <= arst_n && (ptr_evt.req === 1'b1);
      cyc <= cyc + 1;
   end
endmodule // psg_fg_model

// ==== bench/tb_pointer_sequence_generator.sv ====
// Purpose: Self-checking bench for the pointer sequence generator.
// Assumes: Zero-wait APB slave; tick every T core cycles after a start.
// Notes: Long counts stay in ticks, so no run lasts long enough to reach the 30 s repeat.
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
   $display("Error %0t: got %0h want %0h", $time, (a), (b)); end end
module tb_pointer_sequence_generator;
   import psg_pkg::*;
   localparam int T = 2;
   typedef struct {
      psg_mode_t mode;
      logic vt;
      logic dec;
      psg_rate_t rate;
      int n;
      int t[4];
      logic d;
   } psg_row_t;
   // Expected ticks of the first moves after a start with init off.
   // A cancel or an add needs 30 s of slots first, far beyond this run, so no anomaly is due.
   psg_row_t rows[16] = '{
      '{M_SINGLE, 1'b0, 1'b1, 14'h03E8, 1, '{1, 0, 0, 0}, 1'b1},
      '{M_BURST, 1'b0, 1'b0, 14'h03E8, 3, '{1, 2, 3, 0}, 1'b0},
      '{M_BURST, 1'b1, 1'b1, 14'h03E8, 3, '{1, 5, 9, 0}, 1'b1},
      '{M_DALT, 1'b1, 1'b1, 14'h03E8, 2, '{1, 5, 0, 0}, 1'b0},
      '{M_PC, 1'b0, 1'b1, 14'h0022, 4, '{1, 69, 137, 205}, 1'b1},
      '{M_PC_ADD, 1'b0, 1'b0, 14'h0154, 3, '{1, 681, 1361, 0}, 1'b0},
      '{M_PC_ADD, 1'b1, 1'b1, 14'h03E8, 2, '{1, 2001, 0, 0}, 1'b1},
      '{M_PC_CAN, 1'b0, 1'b1, 14'h0022, 2, '{1, 69, 0, 0}, 1'b1},
      '{M_87, 1'b0, 1'b0, 14'h0154, 2, '{1, 681, 0, 0}, 1'b0},
      '{M_87_CAN, 1'b0, 1'b1, 14'h0154, 2, '{1, 681, 0, 0}, 1'b1},
      '{M_87_ADD, 1'b0, 1'b0, 14'h0154, 2, '{1, 681, 0, 0}, 1'b0},
      '{M_26_CAN, 1'b1, 1'b1, 14'h03E8, 2, '{1, 2001, 0, 0}, 1'b1},
      '{M_26_ADD, 1'b1, 1'b0, 14'h03E8, 2, '{1, 2001, 0, 0}, 1'b0},
      '{M_26, 1'b1, 1'b0, 14'h03E8, 3, '{1, 2001, 4001, 0}, 1'b0},
      '{M_PHASE, 1'b0, 1'b1, 14'h03E8, 4, '{1, 501, 1001, 2001}, 1'b1},
      '{M_SALT, 1'b0, 1'b1, 14'h03E8, 1, '{1, 0, 0, 0}, 1'b0}
   };
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [AW-1:0] paddr = 8'h00;
   logic [DW-1:0] pwdata = 32'h0000_0000;
   logic [DW-1:0] prdata;
   logic pready;
   logic pslverr;
   psg_evt_t ptr_evt;
   logic running;
   logic long_pulse;
   logic [DW-1:0] r;
   logic e;
   int err_count = 0;
   int n_tests = 0;
   int s_edge = 0;
   int st;
   int n0;
   psg_row_t row;
   always #50 core_clk = ~core_clk;
   psg_core #(.TICK_CYC(T)) psg_core_i (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ptr_evt(ptr_evt), .running(running));
   psg_fg_model fg_i (.core_clk(core_clk), .arst_n(arst_n), .ptr_evt(ptr_evt),
      .long_pulse(long_pulse));
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // The access edge is remembered in s_edge, as the start of any run it launches.
   task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d);
      int k;
      k = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         err_count++;
         tally_and_finish();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge core_clk);
      s_edge = fg_i.cyc - 1;
   endtask
   function automatic logic [DW-1:0] ctl(psg_mode_t m, logic vt, logic dec, logic ini);
      return {24'h00_0000, m, vt, dec, ini, 1'b1};
   endfunction
   task automatic wait_ticks(input int tk);
      while (fg_i.cyc < st + tk * T) @(posedge core_clk);
   endtask
   initial begin
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         row = rows[i];
         apb(1'b1, RATE_OFS, {18'h0_0000, row.rate});
         n0 = fg_i.stamp.size();
         apb(1'b1, CTRL_OFS, ctl(row.mode, row.vt, row.dec, 1'b0));
         st = s_edge;
         apb(1'b0, STAT_OFS, 32'h0000_0000);
         `CHK(r, 32'h0000_0005)
         wait_ticks(row.t[row.n - 1] + 4);
         `CHK(fg_i.stamp.size() - n0, row.n)
         for (int j = 0; j < row.n; j++) begin
            `CHK(fg_i.stamp[n0 + j], st + row.t[j] * T + 2)
            `CHK(fg_i.dir[n0 + j], row.d)
         end
         apb(1'b1, CTRL_OFS, 32'h0000_0001);
         `CHK(running, 1'b0)
         $display("Row %0d done", i);
      end
      // Initialization burst ahead of the pattern, then a stop that must silence it.
      n0 = fg_i.stamp.size();
      apb(1'b1, CTRL_OFS, ctl(M_SINGLE, 1'b0, 1'b1, 1'b1));
      st = s_edge;
      apb(1'b0, STAT_OFS, 32'h0000_0000);
      `CHK(r, 32'h0000_0003)
      apb(1'b0, CTRL_OFS, 32'h0000_0000);
      `CHK(r, ctl(M_SINGLE, 1'b0, 1'b1, 1'b1))
      wait_ticks(4003);
      `CHK(fg_i.stamp.size() - n0, 2)
      `CHK(fg_i.stamp[n0 + 1] - fg_i.stamp[n0], 2000 * T)
      `CHK(fg_i.stamp[n0], st + 2000 * T + 2)
      `CHK(fg_i.dir[n0 + 1], 1'b1)
      apb(1'b1, CTRL_OFS, 32'h0000_0001);
      wait_ticks(6003);
      `CHK(fg_i.stamp.size() - n0, 2)
      $display("Init run done");
      // Starts that do not suit the pointer type, the mode code or the interval range.
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, RATE_OFS, (i == 3) ? 32'h0000_0021 : 32'h0000_03E8);
         apb(1'b1, CTRL_OFS, ctl((i == 0) ? M_87 : (i == 1) ? M_26_ADD :
            (i == 2) ? psg_mode_t'(4'hE) : M_PC, i == 0, 1'b0, 1'b0));
         `CHK(running, 1'b0)
         apb(1'b0, STAT_OFS, 32'h0000_0000);
         `CHK(r, 32'h0000_0008)
      end
      apb(1'b0, 8'h0C, 32'h0000_0000);
      `CHK(e, 1'b1)
      `CHK(r, 32'h0000_0000)
      $display("Refusal checks done");
      // Reset in mid-run, then the reset values of the registers.
      apb(1'b1, CTRL_OFS, ctl(M_BURST, 1'b0, 1'b0, 1'b0));
      @(posedge core_clk);
      arst_n <= 1'b0;
      @(negedge core_clk);
      `CHK(running, 1'b0)
      `CHK(ptr_evt.req, 1'b0)
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      apb(1'b0, CTRL_OFS, 32'h0000_0000);
      `CHK(r, 32'h0000_0002)
      apb(1'b0, RATE_OFS, 32'h0000_0000);
      `CHK(r, 32'h0000_03E8)
      apb(1'b0, STAT_OFS, 32'h0000_0000);
      `CHK(r, 32'h0000_0000)
      `CHK(long_pulse, 1'b0)
      $display("Reset checks done");
      tally_and_finish();
   end
   initial begin
      #9_000_000;
      err_count++;
      tally_and_finish();
   end
endmodule // tb_pointer_sequence_generator
